/* File: rtl/wake_on_lan_packet_detector.sv */
// The strobed register port was decided locally.
`timescale 1ns/1ps
module wake_on_lan_packet_detector
  import wake_frame_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic rx_valid_in,
  input wire logic rx_last_in,
  input wire logic [7:0] rx_data_in,
  input wire logic [9:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic irq_out,
  output logic gpio_wake_out
);
  // ****************************************
  // carriers
  // ****************************************
  rx_byte_t rx;
  reg_req_t req;

  assign rx = '{valid: rx_valid_in, last: rx_last_in, data: rx_data_in};
  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] basic_mode_control;
  logic [15:0] wake_frame_config;
  logic [15:0] wake_frame_status;
  logic [15:0] wake_frame_mask;
  logic [15:0] station_addr [3];
  logic [15:0] password [3];
  logic [2:0] wake_event;
  logic pattern_wr;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      basic_mode_control <= basic_mode_control_rst;
      wake_frame_config <= wake_frame_config_rst;
      wake_frame_mask <= wake_frame_mask_rst;
    end else if (req.wr) begin
      case (req.addr)
        basic_mode_control_addr: basic_mode_control <= req.wdata;
        wake_frame_config_addr: wake_frame_config <= req.wdata;
        wake_frame_mask_addr: wake_frame_mask <= req.wdata;
        default: ;
      endcase
    end
  end

  // match words; a partial update mid-frame only spoils that frame
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < 3; i++) begin
        station_addr[i] <= 16'h0000;
        password[i] <= 16'h0000;
      end
    end else if (req.wr) begin
      case (req.addr)
        station_addr_base: station_addr[0] <= req.wdata;
        station_addr_base + 10'h001: station_addr[1] <= req.wdata;
        station_addr_base + 10'h002: station_addr[2] <= req.wdata;
        password_base: password[0] <= req.wdata;
        password_base + 10'h001: password[1] <= req.wdata;
        password_base + 10'h002: password[2] <= req.wdata;
        default: ;
      endcase
    end
  end

  assign pattern_wr = req.wr && (req.addr >= pattern_base)
    && (req.addr < pattern_base + 10'(pattern_bytes));

  // status: write one to clear, a new event wins over the clear
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wake_frame_status <= 16'h0000;
    end else begin
      wake_frame_status <= ((req.wr && req.addr == wake_frame_status_addr)
        ? (wake_frame_status & ~req.wdata) : wake_frame_status)
        | {13'h0000, wake_event};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        basic_mode_control_addr: reg_rdata_out <= basic_mode_control;
        wake_frame_config_addr: reg_rdata_out <= wake_frame_config;
        wake_frame_status_addr: reg_rdata_out <= wake_frame_status;
        wake_frame_mask_addr: reg_rdata_out <= wake_frame_mask;
        station_addr_base: reg_rdata_out <= station_addr[0];
        station_addr_base + 10'h001: reg_rdata_out <= station_addr[1];
        station_addr_base + 10'h002: reg_rdata_out <= station_addr[2];
        password_base: reg_rdata_out <= password[0];
        password_base + 10'h001: reg_rdata_out <= password[1];
        password_base + 10'h002: reg_rdata_out <= password[2];
        default: reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  // ****************************************
  // frame tracking
  // ****************************************
  logic in_frame;
  logic first;
  logic [2:0] dest_idx;
  logic dest_ucast;
  logic dest_bcast;
  logic next_dest_ucast;
  logic next_dest_bcast;

  function automatic logic [7:0] pick(input logic [15:0] w [3], input logic [2:0] i);
    logic [15:0] word;
    word = w[i[2:1]];
    return i[0] ? word[15:8] : word[7:0];
  endfunction

  assign first = rx.valid && !in_frame;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      in_frame <= 1'b0;
    end else if (rx.valid) begin
      in_frame <= !rx.last;
    end
  end

  // byte timing comes from the rx path, so every line speed is served
  always_comb begin
    next_dest_ucast = first ? 1'b1 : dest_ucast;
    next_dest_bcast = first ? 1'b1 : dest_bcast;
    if ((first ? 3'h0 : dest_idx) <= addr_len_last) begin
      next_dest_ucast = next_dest_ucast
        && (rx.data == pick(station_addr, first ? 3'h0 : dest_idx));
      next_dest_bcast = next_dest_bcast && (rx.data == sync_byte);
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dest_idx <= 3'h0;
      dest_ucast <= 1'b0;
      dest_bcast <= 1'b0;
    end else if (rx.valid) begin
      dest_idx <= first ? 3'h1 : (dest_idx == 3'h7 ? dest_idx : dest_idx + 3'h1);
      dest_ucast <= next_dest_ucast;
      dest_bcast <= next_dest_bcast;
    end
  end

  // ****************************************
  // wake sequence search
  // ****************************************
  magic_state_t state;
  logic [2:0] sync_cnt;
  logic [2:0] byte_sel;
  logic [3:0] copies;
  logic hit_plain;
  logic hit_pass;
  logic pass_en;

  assign pass_en = wake_frame_config[cfg_pass_en];

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= st_sync;
      sync_cnt <= 3'h0;
      byte_sel <= 3'h0;
      copies <= 4'h0;
      hit_plain <= 1'b0;
      hit_pass <= 1'b0;
    end else if (rx.valid) begin
      if (first) begin
        hit_plain <= 1'b0;
        hit_pass <= 1'b0;
        state <= st_sync;
      end
      case (first ? st_sync : state)
        st_sync: begin
          if (rx.data == sync_byte) begin
            if (first || sync_cnt != 3'h7) begin
              sync_cnt <= (first ? 3'h0 : sync_cnt) + 3'h1;
            end
          end else if (!first && sync_cnt >= sync_len
              && rx.data == pick(station_addr, 3'h0)) begin
            state <= st_addr;
            byte_sel <= 3'h1;
            copies <= 4'h0;
          end else begin
            sync_cnt <= 3'h0;
          end
        end
        st_addr: begin
          if (rx.data == pick(station_addr, byte_sel)) begin
            if (byte_sel == addr_len_last) begin
              byte_sel <= 3'h0;
              copies <= copies + 4'h1;
              if (copies == addr_copies_last) begin
                if (pass_en) begin
                  state <= st_pass;
                end else begin
                  state <= st_done;
                  hit_plain <= 1'b1;
                end
              end
            end else begin
              byte_sel <= byte_sel + 3'h1;
            end
          end else begin
            state <= st_sync;
            sync_cnt <= (rx.data == sync_byte) ? 3'h1 : 3'h0;
          end
        end
        st_pass: begin
          if (rx.data == pick(password, byte_sel)) begin
            if (byte_sel == pass_len_last) begin
              state <= st_done;
              hit_pass <= 1'b1;
            end else begin
              byte_sel <= byte_sel + 3'h1;
            end
          end else begin
            state <= st_sync;
            sync_cnt <= (rx.data == sync_byte) ? 3'h1 : 3'h0;
          end
        end
        st_done: state <= st_done;
        default: state <= st_sync;
      endcase
    end
  end

  // ****************************************
  // crc and pattern
  // ****************************************
  logic crc_good;
  logic pattern_hit;

  wake_crc32 crc_check (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .first_in(first),
    .valid_in(rx.valid),
    .data_in(rx.data),
    .good_out(crc_good)
  );

  wake_pattern_match #(
    .depth(pattern_bytes)
  ) pattern_check (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .wr_in(pattern_wr),
    .wr_idx_in(6'(req.addr - pattern_base)),
    .wr_data_in(req.wdata[7:0]),
    .first_in(first),
    .valid_in(rx.valid),
    .data_in(rx.data),
    .hit_out(pattern_hit)
  );

  // ****************************************
  // end-of-frame decision
  // ****************************************
  logic eval;
  logic eval_crc_ok;
  logic dest_ok;

  // decide one cycle after the last byte, once all match flags settle
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      eval <= 1'b0;
      eval_crc_ok <= 1'b0;
    end else begin
      eval <= rx.valid && rx.last && in_frame;
      eval_crc_ok <= crc_good;
    end
  end

  assign dest_ok = (dest_ucast && wake_frame_config[cfg_ucast_en])
    || (dest_bcast && wake_frame_config[cfg_bcast_en]);

  always_comb begin
    wake_event = 3'h0;
    if (eval && eval_crc_ok && dest_ok) begin
      wake_event[sts_magic] = hit_plain && wake_frame_config[cfg_magic_en];
      wake_event[sts_magic_pass] = hit_pass && wake_frame_config[cfg_magic_en];
      wake_event[sts_pattern] = pattern_hit && wake_frame_config[cfg_pattern_en];
    end
  end

  // ****************************************
  // wake outputs
  // ****************************************
  // registered so a status or mask write never glitches the line
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(wake_frame_status & wake_frame_mask)
        && wake_frame_config[cfg_irq_en]
        && !basic_mode_control[isolate_bit];
    end
  end

  // pin ignores mask and isolate: a separate wake path
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      gpio_wake_out <= 1'b0;
    end else begin
      gpio_wake_out <= |wake_frame_status[2:0] && wake_frame_config[cfg_gpio_en];
    end
  end
endmodule

/* File: rtl/wake_frame_pkg.sv */
package wake_frame_pkg;
  // ****************************************
  // register indices (16-bit words)
  // ****************************************
  localparam logic [9:0] basic_mode_control_addr = 10'h000;
  localparam logic [9:0] wake_frame_config_addr = 10'h134;
  localparam logic [9:0] wake_frame_status_addr = 10'h135;
  localparam logic [9:0] station_addr_base = 10'h136;
  localparam logic [9:0] password_base = 10'h139;
  localparam logic [9:0] wake_frame_mask_addr = 10'h13C;
  localparam logic [9:0] pattern_base = 10'h140;
  localparam int pattern_bytes = 64;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int isolate_bit = 10;
  localparam int cfg_magic_en = 0;
  localparam int cfg_bcast_en = 1;
  localparam int cfg_ucast_en = 2;
  localparam int cfg_pass_en = 3;
  localparam int cfg_pattern_en = 4;
  localparam int cfg_irq_en = 5;
  localparam int cfg_gpio_en = 6;
  localparam int sts_magic = 0;
  localparam int sts_magic_pass = 1;
  localparam int sts_pattern = 2;
  localparam logic [15:0] basic_mode_control_rst = 16'h0000;
  localparam logic [15:0] wake_frame_config_rst = 16'h0000;
  localparam logic [15:0] wake_frame_mask_rst = 16'h0000;
  // ****************************************
  // frame constants
  // ****************************************
  localparam logic [7:0] sync_byte = 8'hFF;
  localparam logic [2:0] sync_len = 3'h6;
  localparam logic [3:0] addr_copies_last = 4'hF;
  localparam logic [2:0] addr_len_last = 3'h5;
  localparam logic [2:0] pass_len_last = 3'h5;
  localparam logic [31:0] crc_poly = 32'hEDB88320;
  localparam logic [31:0] crc_init = 32'hFFFFFFFF;
  localparam logic [31:0] crc_residue = 32'hDEBB20E3;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [1:0] {
    st_sync = 2'b00,
    st_addr = 2'b01,
    st_pass = 2'b11,
    st_done = 2'b10
  } magic_state_t;
endpackage

/* File: rtl/wake_crc32.sv */
`timescale 1ns/1ps
module wake_crc32
  import wake_frame_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic first_in,
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  output logic good_out
);
  logic [31:0] crc;
  logic [31:0] next_crc;

  // ****************************************
  // byte-wise reflected crc
  // ****************************************
  always_comb begin
    next_crc = (first_in ? crc_init : crc) ^ {24'h000000, data_in};
    for (int i = 0; i < 8; i++) begin
      next_crc = next_crc[0] ? ((next_crc >> 1) ^ crc_poly) : (next_crc >> 1);
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      crc <= crc_init;
    end else if (valid_in) begin
      crc <= next_crc;
    end
  end

  // residue over frame plus fcs; valid in the cycle of the last byte
  assign good_out = (next_crc == crc_residue);
endmodule

/* File: rtl/wake_pattern_match.sv */
`timescale 1ns/1ps
module wake_pattern_match
  import wake_frame_pkg::*;
#(
  parameter int depth = pattern_bytes
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic wr_in,
  input wire logic [5:0] wr_idx_in,
  input wire logic [7:0] wr_data_in,
  input wire logic first_in,
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  output logic hit_out
);
  logic [7:0] pattern [depth];
  logic [6:0] idx;
  logic ok;
  logic [6:0] cur_idx;
  logic cur_ok;

  // write index is six bits wide, so no other depth can be served
  if (depth != 64) begin : g_depth_check
    $error("pattern depth must be 64");
  end

  // pattern storage has no reset, software loads it
  always_ff @(posedge core_clk_in) begin
    if (wr_in) begin
      pattern[wr_idx_in] <= wr_data_in;
    end
  end

  assign cur_idx = first_in ? 7'h00 : idx;
  assign cur_ok = first_in ? 1'b1 : ok;

  // compare from the first frame byte, one byte per beat
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      idx <= 7'h00;
      ok <= 1'b0;
      hit_out <= 1'b0;
    end else if (valid_in) begin
      if (cur_idx < 7'(depth)) begin
        idx <= cur_idx + 7'h01;
        ok <= cur_ok && (pattern[cur_idx[5:0]] == data_in);
        hit_out <= (cur_idx == 7'(depth - 1)) && cur_ok && (pattern[cur_idx[5:0]] == data_in);
      end else if (first_in) begin
        hit_out <= 1'b0;
      end
    end
  end
endmodule

/* File: testbench/wake_detector_properties.sv */
`timescale 1ns/1ps
module wake_detector_checker
  import wake_frame_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic rx_valid_in,
  input wire logic rx_last_in,
  input wire logic [9:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic irq_out,
  input wire logic gpio_wake_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // ****************************************
  // shadow copies of written registers
  // ****************************************
  logic [15:0] cfg_sh, mask_sh, bmc_sh;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_sh <= 16'h0000;
      mask_sh <= 16'h0000;
      bmc_sh <= 16'h0000;
    end else if (reg_wr_in) begin
      if (reg_addr_in == wake_frame_config_addr) cfg_sh <= reg_wdata_in;
      if (reg_addr_in == wake_frame_mask_addr) mask_sh <= reg_wdata_in;
      if (reg_addr_in == basic_mode_control_addr) bmc_sh <= reg_wdata_in;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  sequence s_frame_end;
    rx_valid_in && rx_last_in;
  endsequence
  sequence s_rd_cfg;
    reg_rd_in && reg_addr_in == wake_frame_config_addr;
  endsequence
  sequence s_rd_mask;
    reg_rd_in && reg_addr_in == wake_frame_mask_addr;
  endsequence
  sequence s_rd_bmc;
    reg_rd_in && reg_addr_in == basic_mode_control_addr;
  endsequence
  property p_rdata_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000;
  endproperty
  property p_cfg_back;
    s_rd_cfg |=> reg_rdata_out[6:0] == $past(cfg_sh[6:0]);
  endproperty
  property p_mask_back;
    s_rd_mask |=> reg_rdata_out[2:0] == $past(mask_sh[2:0]);
  endproperty
  property p_bmc_back;
    s_rd_bmc |=> reg_rdata_out[isolate_bit] == $past(bmc_sh[isolate_bit]);
  endproperty
  property p_irq_gate;
    irq_out |-> $past(cfg_sh[cfg_irq_en]) && !$past(bmc_sh[isolate_bit]);
  endproperty
  property p_gpio_gate;
    gpio_wake_out |-> $past(cfg_sh[cfg_gpio_en]);
  endproperty
  property p_irq_rise;
    $rose(irq_out) |-> $past(rx_valid_in && rx_last_in, 3) || $past(reg_wr_in, 2);
  endproperty
  property p_irq_fall;
    $fell(irq_out) |-> $past(reg_wr_in, 2);
  endproperty
  property p_gpio_rise;
    $rose(gpio_wake_out) |-> $past(rx_valid_in && rx_last_in, 3) || $past(reg_wr_in, 2);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");
  a_mask_back: assert property (p_mask_back) else $error("mask readback wrong");
  a_bmc_back: assert property (p_bmc_back) else $error("isolate readback wrong");
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
  a_gpio_gate: assert property (p_gpio_gate) else $error("gpio while disabled");
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  a_gpio_rise: assert property (p_gpio_rise) else $error("gpio rose without cause");
  c_frame: cover property (s_frame_end);
endmodule
bind wake_on_lan_packet_detector wake_detector_checker u_chk(.core_clk_in, .reset_in,
  .rx_valid_in, .rx_last_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .irq_out, .gpio_wake_out);

/* File: testbench/frame_source.sv */
`timescale 1ns/1ps
module frame_source (
  input wire logic core_clk_in,
  output logic valid_out,
  output logic last_out,
  output logic [7:0] data_out
);
  initial begin
    valid_out = 1'b0;
    last_out = 1'b0;
    data_out = 8'h00;
  end
  // gap > 0 mimics slow line rates; idle data inverted so stale bytes never match
  task automatic send(input logic [7:0] f[$], input int gap);
    for (int i = 0; i < f.size(); i++) begin
      @(posedge core_clk_in);
      valid_out <= 1'b1;
      last_out <= (i == f.size() - 1);
      data_out <= f[i];
      repeat (gap) begin
        @(posedge core_clk_in);
        valid_out <= 1'b0;
        data_out <= ~f[i];
      end
    end
    @(posedge core_clk_in);
    valid_out <= 1'b0;
    last_out <= 1'b0;
    data_out <= ~f[f.size() - 1];
  endtask
endmodule

/* File: testbench/wake_on_lan_packet_detector_test.sv */
`timescale 1ns/1ps
module wake_on_lan_packet_detector_test;
  import wake_frame_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [9:0] reg_addr_in = 10'h000;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic irq_out, gpio_wake_out, rx_valid, rx_last;
  logic [7:0] rx_data;
  logic [7:0] fr[$];
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam logic [47:0] station = 48'h665544332211;
  localparam logic [47:0] pw = 48'h2F2E2D2C2B2A;
  always #10 core_clk_in = ~core_clk_in;
  frame_source u_src(.core_clk_in, .valid_out(rx_valid), .last_out(rx_last), .data_out(rx_data));
  wake_on_lan_packet_detector u_dut(.core_clk_in, .reset_in, .rx_valid_in(rx_valid),
    .rx_last_in(rx_last), .rx_data_in(rx_data), .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .irq_out, .gpio_wake_out);
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [9:0] a, logic [15:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd_chk(string what, logic [9:0] a, logic [15:0] exp);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 check(what, exp, reg_rdata_out);
  endtask
  function automatic logic [31:0] fcs();
    logic [31:0] c;
    c = crc_init;
    foreach (fr[i]) begin
      c = c ^ {24'h000000, fr[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ crc_poly) : (c >> 1);
    end
    return ~c;
  endfunction
  // a broken copy first, so the breaking FF has to start the real sync run
  task automatic mk(logic [47:0] dst, int copies, logic [47:0] pass, bit bad);
    logic [31:0] f;
    fr = {};
    for (int i = 0; i < 6; i++) fr.push_back(dst[8*i+:8]);
    repeat (6) fr.push_back(8'h0A);
    fr.push_back(8'h08);
    fr.push_back(8'h42);
    repeat (6) fr.push_back(sync_byte);
    fr.push_back(station[7:0]);
    fr.push_back(station[15:8]);
    repeat (6) fr.push_back(sync_byte);
    repeat (copies) for (int i = 0; i < 6; i++) fr.push_back(station[8*i+:8]);
    if (pass !== 48'h0) for (int i = 0; i < 6; i++) fr.push_back(pass[8*i+:8]);
    f = fcs();
    for (int i = 0; i < 4; i++) fr.push_back(f[8*i+:8]);
    if (bad) fr[fr.size() - 1] = ~fr[fr.size() - 1];
  endtask
  task automatic send_chk(int gap, logic [15:0] es, logic ei, logic eg);
    u_src.send(fr, gap);
    repeat (6) @(posedge core_clk_in);
    #1 check("irq_out", 16'(ei), 16'(irq_out));
    check("gpio_wake_out", 16'(eg), 16'(gpio_wake_out));
    rd_chk("status", wake_frame_status_addr, es);
  endtask
  task automatic clr();
    wr(wake_frame_status_addr, 16'h0007);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk("config", wake_frame_config_addr, wake_frame_config_rst);
    rd_chk("status", wake_frame_status_addr, 16'h0000);
    rd_chk("mask", wake_frame_mask_addr, wake_frame_mask_rst);
    rd_chk("basic", basic_mode_control_addr, basic_mode_control_rst);
    rd_chk("unmapped", 10'h3FF, 16'h0000);
    for (int i = 0; i < 3; i++) wr(station_addr_base + 10'(i), station[16*i+:16]);
    for (int i = 0; i < 3; i++) wr(password_base + 10'(i), pw[16*i+:16]);
    $display("test reset done");
  endtask
  task automatic t_magic();
    wr(wake_frame_config_addr, 16'h0025);
    wr(wake_frame_mask_addr, 16'h0007);
    mk(station, 16, 48'h0, 0);
    send_chk(0, 16'h0001, 1'b1, 1'b0);
    wr(wake_frame_mask_addr, 16'h0000);
    repeat (3) @(posedge core_clk_in);
    #1 check("masked irq", 16'h0000, 16'(irq_out));
    wr(wake_frame_mask_addr, 16'h0007);
    clr();
    rd_chk("cleared", wake_frame_status_addr, 16'h0000);
    send_chk(3, 16'h0001, 1'b1, 1'b0);
    clr();
    mk(station, 15, 48'h0, 0);
    send_chk(0, 16'h0000, 1'b0, 1'b0);
    mk(station, 16, 48'h0, 1);
    send_chk(0, 16'h0000, 1'b0, 1'b0);
    $display("test magic done");
  endtask
  task automatic t_dest();
    wr(wake_frame_config_addr, 16'h0023);
    mk(station, 16, 48'h0, 0);
    send_chk(0, 16'h0000, 1'b0, 1'b0);
    mk(48'hFFFFFFFFFFFF, 16, 48'h0, 0);
    send_chk(0, 16'h0001, 1'b1, 1'b0);
    clr();
    $display("test destination done");
  endtask
  task automatic t_pass();
    wr(wake_frame_config_addr, 16'h002D);
    mk(station, 16, pw, 0);
    send_chk(0, 16'h0002, 1'b1, 1'b0);
    clr();
    mk(station, 16, pw ^ 48'h1, 0);
    send_chk(0, 16'h0000, 1'b0, 1'b0);
    $display("test password done");
  endtask
  task automatic t_pattern();
    mk(station, 16, 48'h0, 0);
    for (int i = 0; i < pattern_bytes; i++) wr(pattern_base + 10'(i), {8'h00, fr[i]});
    wr(wake_frame_config_addr, 16'h0034);
    send_chk(0, 16'h0004, 1'b1, 1'b0);
    clr();
    $display("test pattern done");
  endtask
  task automatic t_isolate();
    wr(wake_frame_config_addr, 16'h0065);
    wr(basic_mode_control_addr, 16'h0400);
    mk(station, 16, 48'h0, 0);
    send_chk(0, 16'h0001, 1'b0, 1'b1);
    wr(basic_mode_control_addr, 16'h0000);
    repeat (3) @(posedge core_clk_in);
    #1 check("irq_out", 16'h0001, 16'(irq_out));
    clr();
    repeat (3) @(posedge core_clk_in);
    #1 check("gpio_wake_out", 16'h0000, 16'(gpio_wake_out));
    $display("test isolate done");
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // longest run is some 2k cycles; ceiling leaves margin
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_magic();
    t_dest();
    t_pass();
    t_pattern();
    t_isolate();
    stop_test();
  end
endmodule
